/* File: rtl/bms_regs.svh */
// register map, field positions, reset values and timing figures of the boost supervisor
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_ADDR_W        12
`define BMS_CTRL_ADDR     12'h000
`define BMS_PARAM_ADDR    12'h004
`define BMS_STATUS_ADDR   12'h008
`define BMS_FAULT_ADDR    12'h00C
`define BMS_CTRL_TIMER_RESTART  0
`define BMS_CTRL_PAR_RST  1
`define BMS_CTRL_HZ_SEL   2
`define BMS_CTRL_BOOST    3
`define BMS_CTRL_CHG_EN_N 4
`define BMS_FLT_TMR       0
`define BMS_FLT_OVP       1
`define BMS_FLT_OVLD      2
`define BMS_FLT_BAT       3
`define BMS_FLT_W         4
`define BMS_PARAM_W       8
`define BMS_PARAM_RST     8'h0A
`define BMS_LTMR_W        34
`define BMS_OVLD_W        23
`define BMS_PULSE_W       15
`define BMS_CLK_HZ        200000000
`define BMS_BOOST_TMR_S   32
`define BMS_CRUDE_TMR_S   32
`define BMS_OVLD_MS       30
`define BMS_PULSE_US      128
`define BMS_NPINS         12
`define BMS_PIN_REQ       0
`define BMS_PIN_BUS_OK    1
`define BMS_PIN_BUS_OVP   2
`define BMS_PIN_OVLD      3
`define BMS_PIN_BAT_HIGH  4
`define BMS_PIN_BAT_MIN   5
`define BMS_PIN_BAT_LOWV  6
`define BMS_PIN_CUR_LOW   7
`define BMS_PIN_DROOP     8
`define BMS_PIN_SS_DONE   9
`define BMS_PIN_CHG_FLT   10
`define BMS_PIN_STAT      11
`define BMS_STAT_MODE_W   3
`define BMS_STAT_AUTO     3
`define BMS_STAT_SW       4
`define BMS_STAT_PIN      5
`endif

/* File: rtl/bms_pkg.sv */
// types shared by the boost supervisor modules
`include "bms_regs.svh"
package bms_pkg;
    // operating modes, gray coded along charge configure, charge, hiz, boost configure, boost
    typedef enum logic [2:0] {
        BMS_CHG_CFG   = 3'h0,
        BMS_CHARGE    = 3'h1,
        BMS_HIZ       = 3'h3,
        BMS_BOOST_CFG = 3'h2,
        BMS_BOOST     = 3'h6
    } bms_mode_e;

    // whole state of the supervisor
    typedef struct packed {
        bms_mode_e                  mode;        // current operating mode
        logic                       auto_mode;   // autonomous mode after 32-second crude timer expiry
        logic                       tmr_restart; // self-clearing timer restart bit
        logic                       par_reset;   // self-clearing parameter reset bit
        logic                       hz_sel;      // high_impedance_select
        logic                       boost_sel;   // boost_select
        logic                       chg_en_n;    // charge enable, active low
        logic [`BMS_PARAM_W-1:0]    params;      // charge parameters
        logic [`BMS_FLT_W-1:0]      faults;      // latched fault status
        logic                       switching;   // boost converter switching
        logic                       buck_on;     // buck converter enabled
        logic                       hiz_on;      // bus pin in high impedance
        logic                       soft_start;  // boost soft start active
        logic                       in_switch;   // input_blocking_switch on
        logic [`BMS_LTMR_W-1:0]     boost_cnt;   // boost safety timer
        logic [`BMS_LTMR_W-1:0]     crude_cnt;   // crude host presence timer
        logic [`BMS_OVLD_W-1:0]     ovld_cnt;    // overload persistence count
        logic [`BMS_PULSE_W-1:0]    pulse_cnt;   // status pulse remaining cycles
        logic                       stat_oe;     // status pin pulled low
        logic                       pready;      // apb ready
        logic                       pslverr;     // apb error
        logic [31:0]                prdata;      // apb read data
    } bms_state_s;

    // synchroniser state
    typedef struct packed {
        logic [`BMS_NPINS-1:0] s1;
        logic [`BMS_NPINS-1:0] s2;
        logic [`BMS_NPINS-1:0] s3;
        logic [`BMS_NPINS-1:0] q;
    } bms_sync_s;
endpackage

/* File: rtl/bms_pin_if.sv */
// raw and filtered pin levels passed between supervisor and synchroniser
`timescale 1ns/100ps
`include "bms_regs.svh"
interface bms_pin_if;
    logic [`BMS_NPINS-1:0] raw;   // pin levels as they arrive
    logic [`BMS_NPINS-1:0] clean; // levels after synchronising and agreement
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

/* File: rtl/bms_pin_sync.sv */
// three-stage synchroniser with agreement filter for the supervisor pins
`timescale 1ns/100ps
`include "bms_regs.svh"
module bms_pin_sync
    import bms_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    bms_pin_if.sync   pins
);
    bms_sync_s             st_reg;   // registered state
    bms_sync_s             st_next;  // next state
    logic [`BMS_NPINS-1:0] agree_q;  // filtered level per pin

    // a change counts once the second and third stage agree
    genvar gi;
    generate
        for (gi = 0; gi < `BMS_NPINS; gi++) begin : g_pin
            assign agree_q[gi] = (st_reg.s2[gi] == st_reg.s3[gi]) ? st_reg.s2[gi]
                                                                   : st_reg.q[gi];
        end
    endgenerate

    // shift chain
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pins.raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q  = agree_q;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins.clean = st_reg.q;
endmodule

/* File: rtl/bms_supervisor.sv */
// boost mode and protection supervisor with apb register access
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "bms_regs.svh"
// Operation
// - parameter reset bit restores defaults, self-clears
// - both selects zero: charge, configure, or hiz
// - boost select one: boost, fault gives configure
// - hiz select with request inactive forces hiz
// - 32-second mode boosts on request or select
// - pause switching on low current, resume on droop
// - boost start launches 32-second safety timer
// - timer restart bit restarts timer, self-clears
// - timer expiry stops boost, pulses, latches fault
// - bus overvoltage clears boost select, latches fault
// - boost resumes only on select or request
// - overload is fault after 30 ms persisting
// - overload fault blocks boost until host clears
// - battery out of window stops boost, faults
// - status pin released, one 128 us fault pulse
// - crude timer runs in hiz below low threshold
// - crude expiry enters autonomous mode, stops timer
// - autonomous mode: hiz whenever bus below lockout
// - charge enable bit is active low
// - leave boost on deselect, hiz, low battery, fault
module bms_supervisor
    import bms_pkg::*;
#(
    parameter logic [`BMS_LTMR_W-1:0]  BOOST_TMR_CYC =
        `BMS_LTMR_W'(64'(`BMS_BOOST_TMR_S) * 64'(`BMS_CLK_HZ)),
    parameter logic [`BMS_LTMR_W-1:0]  CRUDE_TMR_CYC =
        `BMS_LTMR_W'(64'(`BMS_CRUDE_TMR_S) * 64'(`BMS_CLK_HZ)),
    parameter logic [`BMS_OVLD_W-1:0]  OVLD_CYC      =
        `BMS_OVLD_W'(64'(`BMS_OVLD_MS) * 64'(`BMS_CLK_HZ) / 64'd1000),
    parameter logic [`BMS_PULSE_W-1:0] PULSE_CYC     =
        `BMS_PULSE_W'(64'(`BMS_PULSE_US) * 64'(`BMS_CLK_HZ) / 64'd1000000)
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`BMS_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    input  wire logic                    boost_request_pin,
    input  wire logic                    bus_above_uvlo,
    input  wire logic                    bus_overvoltage,
    input  wire logic                    output_overload,
    input  wire logic                    battery_above_overvoltage,
    input  wire logic                    battery_below_minimum,
    input  wire logic                    battery_below_low,
    input  wire logic                    inductor_current_low,
    input  wire logic                    boost_output_node_droop,
    input  wire logic                    startup_finished,
    input  wire logic                    charge_fault,
    input  wire logic                    stat_in,
    output logic                         stat_out,
    output logic                         stat_oe,
    output logic                         boost_switch_en,
    output logic                         soft_start_en,
    output logic                         buck_en,
    output logic                         high_impedance_en,
    output logic                         input_blocking_switch,
    output logic [`BMS_PARAM_W-1:0]      charge_params
);
    bms_state_s  st_reg;    // registered state
    bms_state_s  st_next;   // next state
    bms_pin_if   pin_bus(); // raw and filtered pins
    logic [`BMS_NPINS-1:0] pin; // filtered pin levels

    // pins enter through the synchroniser
    assign pin_bus.raw = {stat_in, charge_fault, startup_finished, boost_output_node_droop,
                          inductor_current_low, battery_below_low, battery_below_minimum,
                          battery_above_overvoltage, output_overload, bus_overvoltage,
                          bus_above_uvlo, boost_request_pin};
    assign pin = pin_bus.clean;

    bms_pin_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pins  (pin_bus.sync)
    );

    logic req;        // boost request pin active
    logic bus_ok;     // bus above lockout
    logic bat_ok;     // battery inside its window
    logic in_boost;   // boost configure or boost
    logic boost_blk;  // latched fault refusing boost
    logic hz_now;     // high impedance demanded
    logic want_boost; // boost demanded
    logic ev_tmr;     // boost timer expiry
    logic ev_ovp;     // bus overvoltage in boost
    logic ev_ovld;    // overload persisted past limit
    logic ev_bat;     // battery out of window in boost
    logic any_ev;     // any boost fault this cycle
    logic apb_wr;     // write completes this cycle
    logic ctrl_wr;    // write to control register
    logic flt_wr;     // write to fault register
    logic mapped;     // address decodes to a register
    logic [31:0] rd_mux; // read data for the address

    // qualifying terms for the mode decision
    always_comb begin
        req        = pin[`BMS_PIN_REQ];
        bus_ok     = pin[`BMS_PIN_BUS_OK];
        bat_ok     = !pin[`BMS_PIN_BAT_HIGH] && !pin[`BMS_PIN_BAT_MIN];
        in_boost   = (st_reg.mode == BMS_BOOST_CFG) || (st_reg.mode == BMS_BOOST);
        boost_blk  = st_reg.faults[`BMS_FLT_TMR] || st_reg.faults[`BMS_FLT_OVLD];
        // autonomous mode ignores the select and watches the bus only
        hz_now     = st_reg.auto_mode ? !bus_ok
                                      : (st_reg.hz_sel && !req);
        want_boost = !st_reg.auto_mode && (req || st_reg.boost_sel);
        ev_tmr     = in_boost && (st_reg.boost_cnt == BOOST_TMR_CYC - 1'b1);
        ev_ovp     = (st_reg.mode == BMS_BOOST) && pin[`BMS_PIN_BUS_OVP];
        ev_ovld    = (st_reg.mode == BMS_BOOST) && pin[`BMS_PIN_OVLD]
                     && (st_reg.ovld_cnt == OVLD_CYC);
        ev_bat     = (st_reg.mode == BMS_BOOST) && !bat_ok;
        any_ev     = ev_tmr || ev_ovp || ev_ovld || ev_bat;
    end

    // apb decode and read mux
    always_comb begin
        apb_wr  = psel && penable && st_reg.pready && pwrite;
        ctrl_wr = apb_wr && (paddr == `BMS_CTRL_ADDR);
        flt_wr  = apb_wr && (paddr == `BMS_FAULT_ADDR);
        mapped  = (paddr == `BMS_CTRL_ADDR) || (paddr == `BMS_PARAM_ADDR)
                  || (paddr == `BMS_STATUS_ADDR) || (paddr == `BMS_FAULT_ADDR);
        rd_mux  = 32'h0;
        case (paddr)
            `BMS_CTRL_ADDR: begin
                rd_mux[`BMS_CTRL_TIMER_RESTART]  = st_reg.tmr_restart;
                rd_mux[`BMS_CTRL_PAR_RST]  = st_reg.par_reset;
                rd_mux[`BMS_CTRL_HZ_SEL]   = st_reg.hz_sel;
                rd_mux[`BMS_CTRL_BOOST]    = st_reg.boost_sel;
                rd_mux[`BMS_CTRL_CHG_EN_N] = st_reg.chg_en_n;
            end
            `BMS_PARAM_ADDR: begin
                rd_mux[`BMS_PARAM_W-1:0] = st_reg.params;
            end
            `BMS_STATUS_ADDR: begin
                // mode, autonomous flag, switching, pin level
                rd_mux[`BMS_STAT_MODE_W-1:0] = st_reg.mode;
                rd_mux[`BMS_STAT_AUTO]       = st_reg.auto_mode;
                rd_mux[`BMS_STAT_SW]         = st_reg.switching;
                rd_mux[`BMS_STAT_PIN]        = pin[`BMS_PIN_STAT];
            end
            `BMS_FAULT_ADDR: begin
                rd_mux[`BMS_FLT_W-1:0] = st_reg.faults;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    // next state of the whole supervisor
    always_comb begin
        st_next = st_reg;
        // apb answers one cycle into the access phase
        st_next.pready  = psel && !penable;
        st_next.pslverr = psel && !penable && !mapped;
        st_next.prdata  = (psel && !penable && !pwrite) ? rd_mux : 32'h0;

        // self-clearing bits act one cycle after they are written
        if (st_reg.par_reset) begin
            st_next.params    = `BMS_PARAM_RST;
            st_next.par_reset = 1'b0;
        end
        st_next.tmr_restart = 1'b0;

        // software writes
        if (ctrl_wr) begin
            st_next.tmr_restart = pwdata[`BMS_CTRL_TIMER_RESTART];
            st_next.par_reset   = pwdata[`BMS_CTRL_PAR_RST];
            st_next.hz_sel      = pwdata[`BMS_CTRL_HZ_SEL];
            st_next.boost_sel   = pwdata[`BMS_CTRL_BOOST];
            st_next.chg_en_n    = pwdata[`BMS_CTRL_CHG_EN_N];
            st_next.auto_mode   = 1'b0; // host present again
        end
        if (apb_wr && (paddr == `BMS_PARAM_ADDR)) begin
            st_next.params = pwdata[`BMS_PARAM_W-1:0];
        end
        if (flt_wr) begin
            // write one to clear; a new fault below still wins
            st_next.faults = st_reg.faults & ~pwdata[`BMS_FLT_W-1:0];
        end

        // boost faults latch; all but the timer fault drop the select bit
        if (ev_tmr) begin
            st_next.faults[`BMS_FLT_TMR] = 1'b1;
        end
        if (ev_ovp) begin
            st_next.faults[`BMS_FLT_OVP] = 1'b1;
        end
        if (ev_ovld) begin
            st_next.faults[`BMS_FLT_OVLD] = 1'b1;
        end
        if (ev_bat) begin
            st_next.faults[`BMS_FLT_BAT] = 1'b1;
        end
        if (ev_ovp || ev_ovld || ev_bat) begin
            st_next.boost_sel = 1'b0;
        end

        // mode resolution
        if (hz_now) begin
            st_next.mode = BMS_HIZ;
        end else if (any_ev) begin
            st_next.mode = BMS_CHG_CFG;
        end else if (want_boost) begin
            if (boost_blk || !bat_ok) begin
                st_next.mode = BMS_CHG_CFG;
            end else if (st_reg.mode == BMS_BOOST) begin
                st_next.mode = BMS_BOOST;
            end else if ((st_reg.mode == BMS_BOOST_CFG) && pin[`BMS_PIN_SS_DONE]) begin
                st_next.mode = BMS_BOOST;
            end else begin
                st_next.mode = BMS_BOOST_CFG;
            end
        end else if (!bus_ok) begin
            st_next.mode = BMS_HIZ;
        end else if (pin[`BMS_PIN_CHG_FLT] || st_reg.chg_en_n) begin
            st_next.mode = BMS_CHG_CFG;
        end else begin
            st_next.mode = BMS_CHARGE;
        end

        // boost safety timer, launched on boost entry and on host restart
        if (!in_boost || st_reg.tmr_restart) begin
            st_next.boost_cnt = '0;
        end else if (st_reg.boost_cnt != BOOST_TMR_CYC - 1'b1) begin
            st_next.boost_cnt = st_reg.boost_cnt + 1'b1;
        end

        // overload persistence, current limiting meanwhile
        if ((st_reg.mode == BMS_BOOST) && pin[`BMS_PIN_OVLD]) begin
            if (st_reg.ovld_cnt != OVLD_CYC) begin
                st_next.ovld_cnt = st_reg.ovld_cnt + 1'b1;
            end
        end else begin
            st_next.ovld_cnt = '0;
        end

        // crude host presence timer in high impedance with low battery
        if ((st_reg.mode == BMS_HIZ) && pin[`BMS_PIN_BAT_LOWV] && !st_reg.auto_mode) begin
            if (st_reg.crude_cnt == CRUDE_TMR_CYC - 1'b1) begin
                st_next.auto_mode = 1'b1;
                st_next.crude_cnt = '0;
            end else begin
                st_next.crude_cnt = st_reg.crude_cnt + 1'b1;
            end
        end else begin
            st_next.crude_cnt = '0;
        end

        // light load pulse skipping while boosting
        if ((st_next.mode != BMS_BOOST) && (st_next.mode != BMS_BOOST_CFG)) begin
            st_next.switching = 1'b0;
        end else if (st_reg.mode != BMS_BOOST) begin
            st_next.switching = 1'b1; // soft start switches continuously
        end else if (pin[`BMS_PIN_CUR_LOW]) begin
            st_next.switching = 1'b0;
        end else if (pin[`BMS_PIN_DROOP]) begin
            st_next.switching = 1'b1;
        end

        // status pulse, a fault during a pulse is not counted again
        if (st_reg.pulse_cnt != '0) begin
            st_next.pulse_cnt = st_reg.pulse_cnt - 1'b1;
        end else if (any_ev) begin
            st_next.pulse_cnt = PULSE_CYC;
        end
        st_next.stat_oe = (st_next.pulse_cnt != '0);

        // power path outputs follow the next mode
        st_next.buck_on    = (st_next.mode == BMS_CHARGE);
        st_next.hiz_on     = (st_next.mode == BMS_HIZ);
        st_next.soft_start = (st_next.mode == BMS_BOOST_CFG);
        st_next.in_switch  = (st_next.mode == BMS_CHARGE) || (st_next.mode == BMS_BOOST)
                             || (st_next.mode == BMS_BOOST_CFG);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg        <= '0;
            st_reg.mode   <= BMS_CHG_CFG;
            st_reg.params <= `BMS_PARAM_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign pready                = st_reg.pready;
    assign prdata                = st_reg.prdata;
    assign pslverr               = st_reg.pslverr;
    assign stat_out              = 1'b0 & st_reg.stat_oe;
    assign stat_oe               = st_reg.stat_oe;
    assign boost_switch_en       = st_reg.switching;
    assign soft_start_en         = st_reg.soft_start;
    assign buck_en               = st_reg.buck_on;
    assign high_impedance_en     = st_reg.hiz_on;
    assign input_blocking_switch = st_reg.in_switch;
    assign charge_params         = st_reg.params;

    // checks on the supervisor behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_par_wr;
        ctrl_wr && pwdata[`BMS_CTRL_PAR_RST];
    endsequence
    sequence s_par_done;
        (st_reg.params == `BMS_PARAM_RST) && !st_reg.par_reset;
    endsequence
    sequence s_pulse_start;
        $rose(st_reg.stat_oe);
    endsequence

    chk_param_self_clear: assert property (s_par_wr |=> st_reg.par_reset ##1 s_par_done)
        else $error("parameter reset did not restore defaults");
    chk_tmr_self_clear: assert property (ctrl_wr && pwdata[`BMS_CTRL_TIMER_RESTART] |=> ##1
        (!st_reg.tmr_restart && st_reg.boost_cnt == '0))
        else $error("timer restart did not clear timer and bit");
    chk_hiz_select: assert property (st_reg.hz_sel && !req && !st_reg.auto_mode
        |=> st_reg.mode == BMS_HIZ)
        else $error("high impedance select not obeyed");
    chk_auto_hiz: assert property (st_reg.auto_mode && !bus_ok |=> st_reg.mode == BMS_HIZ)
        else $error("autonomous mode missed high impedance");
    chk_ovp_clears_sel: assert property (ev_ovp |=>
        (!st_reg.boost_sel && st_reg.faults[`BMS_FLT_OVP] && st_reg.mode != BMS_BOOST))
        else $error("bus overvoltage not handled");
    chk_ovld_blocks: assert property (st_reg.faults[`BMS_FLT_OVLD] |->
        (st_reg.mode != BMS_BOOST && st_reg.mode != BMS_BOOST_CFG))
        else $error("boost while overload fault latched");
    chk_ovld_delay: assert property ($rose(st_reg.faults[`BMS_FLT_OVLD]) |->
        $past(st_reg.ovld_cnt) == OVLD_CYC)
        else $error("overload fault before its persistence time");
    chk_pulse_hold: assert property (s_pulse_start |-> st_reg.stat_oe [*8] ##1
        (st_reg.pulse_cnt != PULSE_CYC))
        else $error("status pulse cut short or restarted");
    chk_pfm_stop: assert property (st_reg.mode == BMS_BOOST && pin[`BMS_PIN_CUR_LOW]
        && st_next.mode == BMS_BOOST |=> !st_reg.switching)
        else $error("switching kept on at light load");
    chk_crude_expiry: assert property ((st_reg.mode == BMS_HIZ) && pin[`BMS_PIN_BAT_LOWV]
        && !st_reg.auto_mode && (st_reg.crude_cnt == CRUDE_TMR_CYC - 1'b1)
        |=> st_reg.auto_mode && st_reg.crude_cnt == '0)
        else $error("crude timer expiry did not enter autonomous mode");
    chk_soft_start: assert property ($rose(st_reg.mode == BMS_BOOST) |->
        $past(st_reg.mode) == BMS_BOOST_CFG)
        else $error("boost entered without soft start");
endmodule

/* File: verif/bms_host_model.sv */
// apb host model that drives the supervisor register bus
`timescale 1ns/100ps
`include "bms_regs.svh"
module bms_host_model (
    input  wire logic                  clk,
    output logic                       psel,
    output logic                       penable,
    output logic                       pwrite,
    output logic [`BMS_ADDR_W-1:0]     paddr,
    output logic [31:0]                pwdata,
    input  wire logic                  pready,
    input  wire logic [31:0]           prdata,
    input  wire logic                  pslverr
);
    // bus idles with no request
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // setup cycle, then access held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [`BMS_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule

/* File: verif/boost_mode_supervisor_bench.sv */
// self-checking bench for the boost mode supervisor
`timescale 1ns/100ps
`include "bms_regs.svh"
module boost_mode_supervisor_bench;
    logic                   clk = 1'b0;   // 200 MHz clock
    logic                   rst_n = 1'b0; // async reset, active low
    logic                   psel, penable, pwrite, pready, pslverr, stat_oe, stat_out, err;
    logic [`BMS_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic [7:0]             cp;           // charge parameters seen
    logic [4:0]             en;           // power path enables
    logic [`BMS_NPINS-1:0]  pin = '0;     // comparator levels
    int                     fail_count = 0;
    int                     n_compared = 0;
    int                     cyc = 0;
    always #2.5 clk = ~clk;
    bms_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    bms_supervisor #(.BOOST_TMR_CYC(34'h0C8), .CRUDE_TMR_CYC(34'h064), .OVLD_CYC(23'h032),
        .PULSE_CYC(15'h014))
    dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .boost_request_pin(pin[0]), .bus_above_uvlo(pin[1]), .bus_overvoltage(pin[2]),
        .output_overload(pin[3]), .battery_above_overvoltage(pin[4]),
        .battery_below_minimum(pin[5]), .battery_below_low(pin[6]),
        .inductor_current_low(pin[7]), .boost_output_node_droop(pin[8]),
        .startup_finished(pin[9]), .charge_fault(pin[10]), .stat_in(~stat_oe),
        .stat_out(stat_out), .stat_oe(stat_oe), .boost_switch_en(en[4]), .soft_start_en(en[3]),
        .buck_en(en[2]), .high_impedance_en(en[1]), .input_blocking_switch(en[0]),
        .charge_params(cp));
    // compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask
    // read until masked field settles, bounded, then compare
    task automatic poll(input string nm, input logic [11:0] a, input logic [31:0] m, e);
        for (int i = 0; i < 40; i++) begin
            host.xfer(1'b0, a, 32'h0, rd, err);
            if ((rd & m) === e) break;
        end
        chk(nm, e, rd & m);
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        int n;
        pin[1] = 1'b1;
        pin[9] = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        poll("param", 12'h004, 32'hFF, 32'h0A);
        wr(12'h004, 32'h55);
        wr(12'h000, 32'h02);
        poll("param", 12'h004, 32'hFF, 32'h0A);
        poll("par_rst", 12'h000, 32'h02, 32'h00);
        chk("cp", 32'h0A, {24'h0, cp});
        host.xfer(1'b0, 12'h010, 32'h0, rd, err);
        chk("slverr", 32'h1, {31'h0, err});
        poll("charge", 12'h008, 32'h07, 32'h01);
        chk("en_chg", 32'h05, {27'h0, en});
        wr(12'h000, 32'h10);
        poll("ce_n", 12'h008, 32'h07, 32'h00);
        wr(12'h000, 32'h08);
        poll("boost", 12'h008, 32'h07, 32'h06);
        repeat (3) begin
            repeat (100) @(posedge clk);
            wr(12'h000, 32'h09);
        end
        poll("kick", 12'h008, 32'h07, 32'h06);
        n = 0;
        for (int i = 0; i < 400 && stat_oe !== 1'b1; i++) @(posedge clk);
        chk("stat_out", 32'h0, {31'h0, stat_out});
        while (stat_oe === 1'b1 && n < 99) begin
            @(posedge clk);
            n++;
        end
        chk("pulse", 32'd20, n);
        poll("tmr_flt", 12'h00C, 32'h01, 32'h01);
        poll("tmr_mode", 12'h008, 32'h07, 32'h00);
        wr(12'h00C, 32'h0F);
        wr(12'h000, 32'h08);
        poll("boost2", 12'h008, 32'h07, 32'h06);
        pin[2] <= 1'b1;
        poll("ovp_flt", 12'h00C, 32'h02, 32'h02);
        poll("ovp_sel", 12'h000, 32'h08, 32'h00);
        pin[2] <= 1'b0;
        poll("no_rest", 12'h008, 32'h07, 32'h01);
        wr(12'h00C, 32'h0F);
        wr(12'h000, 32'h04);
        poll("hiz", 12'h008, 32'h07, 32'h03);
        chk("en_hiz", 32'h02, {27'h0, en});
        pin[0] <= 1'b1;
        poll("req", 12'h008, 32'h07, 32'h06);
        chk("en_boost", 32'h11, {27'h0, en});
        pin[7] <= 1'b1;
        poll("pfm_off", 12'h008, 32'h10, 32'h00);
        {pin[8], pin[7]} <= 2'b10;
        poll("pfm_on", 12'h008, 32'h10, 32'h10);
        pin[3] <= 1'b1;
        poll("ovld", 12'h00C, 32'h04, 32'h04);
        {pin[9], pin[3]} <= 2'b00;
        repeat (10) @(posedge clk);
        poll("ovld_blk", 12'h008, 32'h07, 32'h00);
        wr(12'h00C, 32'h0F);
        poll("ss_cfg", 12'h008, 32'h07, 32'h02);
        chk("en_cfg", 32'h19, {27'h0, en});
        pin[9] <= 1'b1;
        poll("ss_done", 12'h008, 32'h07, 32'h06);
        pin[5] <= 1'b1;
        poll("bat_flt", 12'h00C, 32'h08, 32'h08);
        pin[5] <= 1'b0;
        poll("bat_back", 12'h008, 32'h07, 32'h06);
        {pin[6], pin[0]} <= 2'b10;
        repeat (60) @(posedge clk);
        poll("auto", 12'h008, 32'h08, 32'h08);
        poll("auto_chg", 12'h008, 32'h07, 32'h01);
        pin[1] <= 1'b0;
        poll("auto_hiz", 12'h008, 32'h07, 32'h03);
        test_done();
    end
endmodule
